// ---- pin_mux_defs.svh ----
`ifndef PIN_MUX_DEFS_SVH
`define PIN_MUX_DEFS_SVH

// ----------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define PM_ADDR_W                     8
`define PM_NUM_REGS                   7
`define PM_FIRST_IDX                  6'h13
`define PM_PORT_A_SELECT_LOW_IDX      6'h13
`define PM_PORT_A_SELECT_HIGH_IDX     6'h14
`define PM_PORT_B_SELECT_LOW_IDX      6'h15
`define PM_PORT_B_SELECT_HIGH_IDX     6'h16
`define PM_PORT_C_D_SELECT_IDX        6'h17
`define PM_PWM_INPUT_SOURCE_IDX       6'h18
`define PM_CONVERTER_INPUT_SOURCE_IDX 6'h19

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define PM_PB_LINE11_BIT              8
`define PM_PB_LINE10_BIT              6
`define PM_PB_LINE7_BIT               0
`define PM_PD_LINE5_BIT               12
`define PM_FAULT_TWO_BIT              13
`define PM_FAULT_ONE_BIT              11
`define PM_PAIR_TWO_MSB               8
`define PM_PAIR_TWO_LSB               6

// ----------------------------------------------------------------------------
// Pair source encodings
// ----------------------------------------------------------------------------
`define PM_PAIR_TIMER                 3'h1
`define PM_PAIR_ADC                   3'h2
`define PM_PAIR_CMP_A                 3'h3
`define PM_PAIR_CMP_B                 3'h4

// ----------------------------------------------------------------------------
// Reset value and writable bits per register
// ----------------------------------------------------------------------------
`define PM_RESET_VALUE                16'h0000
`define PM_WMASK_FULL                 16'hffff
`define PM_WMASK_PORT_B_HIGH          16'h0141
`define PM_WMASK_PORT_C_D             16'h1000
`define PM_WMASK_PWM_SOURCE           16'h29ff

// ----------------------------------------------------------------------------
// Bus responses
// ----------------------------------------------------------------------------
`define PM_RESP_OKAY                  2'h0
`define PM_RESP_SLVERR                2'h2

`endif

// ---- pin_mux_pkg.sv ----
`default_nettype none
package pin_mux_pkg;
    typedef logic [15:0] reg_word_t;
    typedef logic [11:0] adc_word_t;
    typedef logic [2:0]  pair_sel_t;
endpackage
`default_nettype wire

// ---- pwm_pair_source.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "pin_mux_defs.svh"

module pwm_pair_source
(
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    input  wire pin_mux_pkg::pair_sel_t sel,
    input  wire logic                   timer_a_channel3_out,
    input  wire logic                   comparator_a_output,
    input  wire logic                   comparator_b_output,
    input  wire pin_mux_pkg::adc_word_t adc_result_slot2,
    input  wire pin_mux_pkg::adc_word_t slot2_high_limit,
    input  wire pin_mux_pkg::adc_word_t slot2_low_limit,
    output var  logic                   pwm_channel_four,
    output var  logic                   pwm_channel_five
);
    import pin_mux_pkg::*;

    logic src_bit;
    logic above_high;
    logic below_low;

    assign above_high = adc_result_slot2 > slot2_high_limit;
    assign below_low  = adc_result_slot2 < slot2_low_limit;

    always_comb
    begin
        case (sel)
            `PM_PAIR_TIMER: src_bit = timer_a_channel3_out;
            `PM_PAIR_CMP_A: src_bit = comparator_a_output;
            `PM_PAIR_CMP_B: src_bit = comparator_b_output;
            default:        src_bit = 1'b0;
        endcase
    end

    // Inside the limit window the pair keeps its last state
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pwm_channel_four <= 1'b0;
            pwm_channel_five <= 1'b0;
        end
        else if (sel == `PM_PAIR_ADC)
        begin
            if (above_high)
            begin
                pwm_channel_four <= 1'b0;
                pwm_channel_five <= 1'b1;
            end
            else if (below_low)
            begin
                pwm_channel_four <= 1'b1;
                pwm_channel_five <= 1'b0;
            end
        end
        else if (sel == `PM_PAIR_TIMER || sel == `PM_PAIR_CMP_A || sel == `PM_PAIR_CMP_B)
        begin
            pwm_channel_four <= src_bit;
            pwm_channel_five <= !src_bit;
        end
        else
        begin
            // Reserved codes park the pair low rather than guess a source
            pwm_channel_four <= 1'b0;
            pwm_channel_five <= 1'b0;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    adc_high_a: assert property ($past(aresetn) && $past(sel) == `PM_PAIR_ADC
        && $past(above_high) |-> !pwm_channel_four && pwm_channel_five)
        else $error("pair not driven 0/1 above high limit");

    adc_low_a: assert property ($past(aresetn) && $past(sel) == `PM_PAIR_ADC
        && !$past(above_high) && $past(below_low) |-> pwm_channel_four && !pwm_channel_five)
        else $error("pair not driven 1/0 below low limit");

    pair_decode_a: assert property ($past(aresetn) && $past(sel) == `PM_PAIR_CMP_B
        |-> pwm_channel_four == $past(comparator_b_output)
        && pwm_channel_five == !$past(comparator_b_output))
        else $error("pair does not follow comparator B");

endmodule
`default_nettype wire

// ---- pin_function_source_select.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "pin_mux_defs.svh"

module pin_function_source_select
(
    input  wire logic                     aclk,
    input  wire logic                     aresetn,
    input  wire logic [`PM_ADDR_W-1:0]    awaddr,
    input  wire logic [2:0]               awprot,
    input  wire logic                     awvalid,
    output var  logic                     awready,
    input  wire logic [31:0]              wdata,
    input  wire logic [3:0]               wstrb,
    input  wire logic                     wvalid,
    output var  logic                     wready,
    output var  logic [1:0]               bresp,
    output var  logic                     bvalid,
    input  wire logic                     bready,
    input  wire logic [`PM_ADDR_W-1:0]    araddr,
    input  wire logic [2:0]               arprot,
    input  wire logic                     arvalid,
    output var  logic                     arready,
    output var  logic [31:0]              rdata,
    output var  logic [1:0]               rresp,
    output var  logic                     rvalid,
    input  wire logic                     rready,
    input  wire logic                     comparator_a_output,
    input  wire logic                     comparator_b_output,
    input  wire logic                     serial_transmit_line,
    input  wire logic                     i2c_serial_clock,
    input  wire logic                     fault_one_pin,
    input  wire logic                     fault_two_pin,
    input  wire logic                     timer_a_channel3_out,
    input  wire pin_mux_pkg::adc_word_t   adc_result_slot2,
    input  wire pin_mux_pkg::adc_word_t   slot2_high_limit,
    input  wire pin_mux_pkg::adc_word_t   slot2_low_limit,
    output var  logic                     port_b_line_eleven,
    output var  logic                     port_b_line_ten,
    output var  logic                     port_b_line_seven,
    output var  logic                     port_d_line5_func_sel,
    output var  logic                     fault_input_one,
    output var  logic                     fault_input_two,
    output var  logic                     pwm_channel_four,
    output var  logic                     pwm_channel_five
);
    import pin_mux_pkg::*;

    // ------------------------------------------------------------------------
    // Register slots
    // ------------------------------------------------------------------------
    localparam logic [2:0] SLOT_PB_HI = 3'(`PM_PORT_B_SELECT_HIGH_IDX - `PM_FIRST_IDX);
    localparam logic [2:0] SLOT_CD    = 3'(`PM_PORT_C_D_SELECT_IDX - `PM_FIRST_IDX);
    localparam logic [2:0] SLOT_PWM   = 3'(`PM_PWM_INPUT_SOURCE_IDX - `PM_FIRST_IDX);
    localparam reg_word_t  WMASK [0:`PM_NUM_REGS-1] = '{
        `PM_WMASK_FULL, `PM_WMASK_FULL, `PM_WMASK_FULL, `PM_WMASK_PORT_B_HIGH,
        `PM_WMASK_PORT_C_D, `PM_WMASK_PWM_SOURCE, `PM_WMASK_FULL};

    reg_word_t            regs_q [0:`PM_NUM_REGS-1];
    reg_word_t            regs_d [0:`PM_NUM_REGS-1];

    logic                 aw_hold_q;
    logic [`PM_ADDR_W-1:0] awaddr_q;
    logic                 w_hold_q;
    logic [15:0]          wdata_q;
    logic [1:0]           wstrb_q;
    logic                 aw_take;
    logic                 w_take;
    logic                 have_aw;
    logic                 have_w;
    logic                 do_write;
    logic                 bvalid_d;
    logic [`PM_ADDR_W-1:0] wr_addr;
    logic [15:0]          wr_data;
    logic [15:0]          wr_lanes;
    logic [5:0]           wr_idx;
    logic                 wr_hit;
    logic [2:0]           wr_slot;
    logic                 ar_take;
    logic [5:0]           rd_idx;
    logic                 rd_hit;
    logic [2:0]           rd_slot;
    logic                 rvalid_d;

    // ------------------------------------------------------------------------
    // Write channel
    // ------------------------------------------------------------------------
    // Address and data are taken in either order and held until both are in
    assign aw_take  = awvalid && awready;
    assign w_take   = wvalid && wready;
    assign have_aw  = aw_hold_q || aw_take;
    assign have_w   = w_hold_q || w_take;
    assign do_write = have_aw && have_w && !bvalid;
    assign bvalid_d = do_write || (bvalid && !bready);
    assign wr_addr  = aw_hold_q ? awaddr_q : awaddr;
    assign wr_data  = w_hold_q ? wdata_q : wdata[15:0];
    assign wr_lanes = w_hold_q ? {{8{wstrb_q[1]}}, {8{wstrb_q[0]}}}
                               : {{8{wstrb[1]}}, {8{wstrb[0]}}};
    assign wr_idx   = wr_addr[`PM_ADDR_W-1:2];
    assign wr_hit   = wr_idx >= `PM_FIRST_IDX
                      && wr_idx <= `PM_CONVERTER_INPUT_SOURCE_IDX;
    assign wr_slot  = 3'(wr_idx - `PM_FIRST_IDX);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_hold_q <= 1'b0;
            awaddr_q  <= '0;
            awready   <= 1'b0;
        end
        else
        begin
            aw_hold_q <= have_aw && !do_write;
            awready   <= !(have_aw && !do_write) && !bvalid_d;
            if (aw_take)
            begin
                awaddr_q <= awaddr;
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            w_hold_q <= 1'b0;
            wdata_q  <= '0;
            wstrb_q  <= '0;
            wready   <= 1'b0;
        end
        else
        begin
            w_hold_q <= have_w && !do_write;
            wready   <= !(have_w && !do_write) && !bvalid_d;
            if (w_take)
            begin
                wdata_q <= wdata[15:0];
                wstrb_q <= wstrb[1:0];
            end
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid <= 1'b0;
            bresp  <= `PM_RESP_OKAY;
        end
        else
        begin
            bvalid <= bvalid_d;
            if (do_write)
            begin
                bresp <= wr_hit ? `PM_RESP_OKAY : `PM_RESP_SLVERR;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Select registers
    // ------------------------------------------------------------------------
    // Reserved bits are not stored, so they read back zero whatever is written
    generate
        for (genvar i = 0; i < `PM_NUM_REGS; i++)
        begin : g_reg
            always_comb
            begin
                regs_d[i] = regs_q[i];
                if (do_write && wr_hit && wr_slot == 3'(i))
                begin
                    regs_d[i] = ((regs_q[i] & ~wr_lanes) | (wr_data & wr_lanes))
                                & WMASK[i];
                end
            end

            always_ff @(posedge aclk)
            begin
                if (!aresetn)
                begin
                    regs_q[i] <= `PM_RESET_VALUE;
                end
                else
                begin
                    regs_q[i] <= regs_d[i];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------------------
    assign ar_take  = arvalid && arready;
    assign rd_idx   = araddr[`PM_ADDR_W-1:2];
    assign rd_hit   = rd_idx >= `PM_FIRST_IDX
                      && rd_idx <= `PM_CONVERTER_INPUT_SOURCE_IDX;
    assign rd_slot  = 3'(rd_idx - `PM_FIRST_IDX);
    assign rvalid_d = ar_take || (rvalid && !rready);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            arready <= 1'b0;
            rvalid  <= 1'b0;
            rdata   <= '0;
            rresp   <= `PM_RESP_OKAY;
        end
        else
        begin
            arready <= !rvalid_d;
            rvalid  <= rvalid_d;
            if (ar_take)
            begin
                rdata <= rd_hit ? {16'h0000, regs_q[rd_slot]} : 32'h0000_0000;
                rresp <= rd_hit ? `PM_RESP_OKAY : `PM_RESP_SLVERR;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Pin and source multiplexers
    // ------------------------------------------------------------------------
    // Driven from the next register value so a write takes effect at the
    // same edge that stores it, while the outputs still come from flops
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            port_b_line_eleven    <= 1'b0;
            port_b_line_ten       <= 1'b0;
            port_b_line_seven     <= 1'b0;
            port_d_line5_func_sel <= 1'b0;
        end
        else
        begin
            // Code 1 on lines 11 and 10 is reserved: pin is held low
            port_b_line_eleven <= !regs_d[SLOT_PB_HI][`PM_PB_LINE11_BIT]
                                  && comparator_b_output;
            port_b_line_ten    <= !regs_d[SLOT_PB_HI][`PM_PB_LINE10_BIT]
                                  && comparator_a_output;
            port_b_line_seven  <= regs_d[SLOT_PB_HI][`PM_PB_LINE7_BIT]
                                  ? i2c_serial_clock : serial_transmit_line;
            port_d_line5_func_sel <= regs_d[SLOT_CD][`PM_PD_LINE5_BIT];
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            fault_input_one <= 1'b0;
            fault_input_two <= 1'b0;
        end
        else
        begin
            fault_input_two <= regs_d[SLOT_PWM][`PM_FAULT_TWO_BIT]
                               ? comparator_b_output : fault_two_pin;
            fault_input_one <= regs_d[SLOT_PWM][`PM_FAULT_ONE_BIT]
                               ? comparator_a_output : fault_one_pin;
        end
    end

    pwm_pair_source u_pair
    (
        .aclk                 (aclk),
        .aresetn              (aresetn),
        .sel                  (regs_d[SLOT_PWM][`PM_PAIR_TWO_MSB:`PM_PAIR_TWO_LSB]),
        .timer_a_channel3_out (timer_a_channel3_out),
        .comparator_a_output  (comparator_a_output),
        .comparator_b_output  (comparator_b_output),
        .adc_result_slot2     (adc_result_slot2),
        .slot2_high_limit     (slot2_high_limit),
        .slot2_low_limit      (slot2_low_limit),
        .pwm_channel_four     (pwm_channel_four),
        .pwm_channel_five     (pwm_channel_five)
    );

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence pwm_reg_write;
        do_write && wr_hit && wr_slot == SLOT_PWM && wr_lanes[15];
    endsequence

    sequence pd_reg_read;
        ar_take && rd_hit && rd_slot == SLOT_CD ##1 rvalid;
    endsequence

    line_eleven_a: assert property ($past(aresetn) |-> port_b_line_eleven ==
        (!regs_q[SLOT_PB_HI][`PM_PB_LINE11_BIT] && $past(comparator_b_output)))
        else $error("line 11 not comparator B");

    line_ten_a: assert property ($past(aresetn) |-> port_b_line_ten ==
        (!regs_q[SLOT_PB_HI][`PM_PB_LINE10_BIT] && $past(comparator_a_output)))
        else $error("line 10 not comparator A");

    line_seven_a: assert property ($past(aresetn) && regs_q[SLOT_PB_HI][`PM_PB_LINE7_BIT]
        |-> port_b_line_seven == $past(i2c_serial_clock))
        else $error("line 7 not serial clock when selected");

    reserved_zero_a: assert property (regs_q[SLOT_PB_HI][7] == 1'b0
        && regs_q[SLOT_PWM][12] == 1'b0)
        else $error("reserved select bit stored");

    cd_read_a: assert property (pd_reg_read |-> (rdata & ~32'h0000_1000) == 32'h0)
        else $error("port C/D read shows bits beyond line 5");

    fault_two_a: assert property (pwm_reg_write |=> fault_input_two ==
        ($past(wr_data[`PM_FAULT_TWO_BIT]) ? $past(comparator_b_output)
                                           : $past(fault_two_pin)))
        else $error("fault two source not applied after write");

    fault_one_a: assert property ($past(aresetn) |-> fault_input_one ==
        (regs_q[SLOT_PWM][`PM_FAULT_ONE_BIT] ? $past(comparator_a_output)
                                             : $past(fault_one_pin)))
        else $error("fault one source wrong");

    select_reset_a: assert property ($past(!aresetn) |-> regs_q[SLOT_PWM] == 16'h0000
        && regs_q[SLOT_PB_HI] == 16'h0000 && !fault_input_one && !pwm_channel_four)
        else $error("select not cleared by reset");

endmodule
`default_nettype wire

// ---- periph_model.sv ----
`timescale 1ns/10ps
`default_nettype none
// ---------------------------------
// Peripheral levels feeding the mux
// ---------------------------------
module periph_model
(
    input  wire logic                   aclk,
    output var  logic [6:0]             lv,
    output var  pin_mux_pkg::adc_word_t sample,
    output var  pin_mux_pkg::adc_word_t hlim,
    output var  pin_mux_pkg::adc_word_t llim
);
    import pin_mux_pkg::*;
    int seed = 32;
    // New levels every cycle so each select path sees both values
    always @(posedge aclk)
    begin
        lv     <= 7'($random(seed));
        sample <= 12'($random(seed));
        hlim   <= 12'($random(seed));
        llim   <= 12'($random(seed));
    end
    initial
    begin
        lv = 7'h00;
        sample = 12'h000;
        hlim = 12'h000;
        llim = 12'h000;
    end
endmodule
`default_nettype wire

// ---- pin_function_source_select_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "pin_mux_defs.svh"
module pin_function_source_select_tb;
    import pin_mux_pkg::*;
    // ------------------------------
    // Bus, levels and reference
    // ------------------------------
    logic             aclk = 1'b0, aresetn = 1'b0;
    logic [7:0]       awaddr = 8'h00, araddr = 8'h00;
    logic [31:0]      wdata = 32'h0, d;
    logic [3:0]       wstrb = 4'h0;
    logic             awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    wire logic        awready, wready, bvalid, arready, rvalid;
    wire logic [1:0]  bresp, rresp;
    wire logic [31:0] rdata;
    wire logic [7:0]  pins;
    wire logic [6:0]  lv;
    wire adc_word_t   sample, hlim, llim;
    logic [15:0]      regs [7] = '{default: 16'h0};
    logic [7:0]       exp_q = 8'h00;
    int               seed = 32, err_count = 0, n_tests = 0, cycles = 0, k;

    pin_function_source_select dut
    (
        .aclk, .aresetn, .awaddr, .awprot(3'h0), .awvalid, .awready, .wdata, .wstrb, .wvalid,
        .wready, .bresp, .bvalid, .bready, .araddr, .arprot(3'h0), .arvalid, .arready, .rdata,
        .rresp, .rvalid, .rready, .comparator_a_output(lv[0]), .comparator_b_output(lv[1]),
        .serial_transmit_line(lv[2]), .i2c_serial_clock(lv[3]), .fault_one_pin(lv[4]),
        .fault_two_pin(lv[5]), .timer_a_channel3_out(lv[6]), .adc_result_slot2(sample),
        .slot2_high_limit(hlim), .slot2_low_limit(llim), .port_b_line_eleven(pins[7]),
        .port_b_line_ten(pins[6]), .port_b_line_seven(pins[5]), .port_d_line5_func_sel(pins[4]),
        .fault_input_one(pins[3]), .fault_input_two(pins[2]), .pwm_channel_four(pins[1]),
        .pwm_channel_five(pins[0])
    );
    periph_model peer (.aclk, .lv, .sample, .hlim, .llim);

    always #5 aclk = ~aclk;

    function automatic logic [7:0] addr_of(input int i);
        return 8'((`PM_FIRST_IDX + i) * 4);
    endfunction

    function automatic logic [15:0] wmask(input int i);
        case (i)
            3: return 16'h0141;
            4: return 16'h1000;
            5: return 16'h29ff;
            default: return 16'hffff;
        endcase
    endfunction

    // Pair outputs hold between the limits, so the previous pair is an input
    function automatic logic [7:0] ref_pins(input logic [1:0] pr);
        logic [15:0] b;
        logic [15:0] s;
        logic [1:0]  p;
        b = regs[3];
        s = regs[5];
        case (s[8:6])
            `PM_PAIR_TIMER: p = {lv[6], ~lv[6]};
            `PM_PAIR_ADC:   p = (sample > hlim) ? 2'b01 : ((sample < llim) ? 2'b10 : pr);
            `PM_PAIR_CMP_A: p = {lv[0], ~lv[0]};
            `PM_PAIR_CMP_B: p = {lv[1], ~lv[1]};
            default:        p = 2'b00;
        endcase
        return {b[8] ? 1'b0 : lv[1], b[6] ? 1'b0 : lv[0], b[0] ? lv[3] : lv[2], regs[4][12],
                s[11] ? lv[0] : lv[4], s[13] ? lv[1] : lv[5], p};
    endfunction

    always @(posedge aclk)
    begin
        exp_q <= aresetn ? ref_pins(exp_q[1:0]) : 8'h00;
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            err_count++;
            print_verdict();
        end
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic chk_pins(input int n);
        repeat (n)
        begin
            @(posedge aclk);
            #1;
            chk("pins", 32'(pins), 32'(exp_q));
        end
    endtask

    task automatic wr(input int i, input logic [31:0] v, input logic [3:0] s,
                      input logic [1:0] er);
        logic [15:0] bm;
        logic        aw;
        logic        w;
        bm = {{8{s[1]}}, {8{s[0]}}};
        aw = 1'b0;
        w = 1'b0;
        @(posedge aclk);
        awaddr <= addr_of(i);
        wdata <= v;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        if (i >= 0 && i < 7)
            regs[i] <= ((regs[i] & ~bm) | (v[15:0] & bm)) & wmask(i);
        while (!(aw && w))
        begin
            @(posedge aclk);
            aw = aw | (awready === 1'b1);
            w = w | (wready === 1'b1);
            if (aw)
                awvalid <= 1'b0;
            if (w)
                wvalid <= 1'b0;
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk("bresp", {30'h0, bresp}, {30'h0, er});
    endtask

    task automatic rd(input int i, input logic [1:0] er);
        logic [31:0] exp;
        exp = (i >= 0 && i < 7) ? {16'h0, regs[i]} : 32'h0;
        @(posedge aclk);
        araddr <= addr_of(i);
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        rready <= 1'b0;
        chk("rdata", rdata, exp);
        chk("rresp", {30'h0, rresp}, {30'h0, er});
    endtask

    // Pins are checked low while reset is held, then the shadow clears
    task automatic do_reset(input int n);
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (n - 1) @(posedge aclk);
        #1;
        chk("reset pins", {24'h0, pins}, 32'h0);
        @(posedge aclk);
        aresetn <= 1'b1;
        foreach (regs[j]) regs[j] = 16'h0;
        for (int j = 0; j < 7; j++) rd(j, `PM_RESP_OKAY);
    endtask

    task automatic print_verdict();
        $display("Checks made %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    initial
    begin
        do_reset(20);
        $display("reset values test done");
        // Reserved port B bits stay zero on write; bit 7 is left random
        repeat (40)
        begin
            k = ($random(seed) & 32'h7fffffff) % 7;
            d = $random(seed);
            if (k == 3)
                d[15:0] = d[15:0] & 16'h01c1;
            wr(k, d, 4'($random(seed)), `PM_RESP_OKAY);
            rd(k, `PM_RESP_OKAY);
            chk_pins(3);
        end
        $display("random select test done");
        for (int c = 0; c < 8; c++)
        begin
            d = $random(seed) | 32'h1600;
            d[8:6] = 3'(c);
            wr(5, d, 4'hf, `PM_RESP_OKAY);
            rd(5, `PM_RESP_OKAY);
            chk_pins(12);
        end
        $display("pair source test done");
        wr(-1, 32'hffff, 4'hf, `PM_RESP_SLVERR);
        wr(7, 32'hffff, 4'hf, `PM_RESP_SLVERR);
        rd(-1, `PM_RESP_SLVERR);
        rd(7, `PM_RESP_SLVERR);
        rd(0, `PM_RESP_OKAY);
        $display("unmapped access test done");
        do_reset(3);
        chk_pins(4);
        $display("mid-run reset test done");
        print_verdict();
    end
endmodule
`default_nettype wire
